//--- mfos_flash.sv
// Flash code sequencer: groups of flashes, optional second group, then pause
// Assumes a one-cycle tick enable from the top module's divider
`timescale 1ns/1ps
`default_nettype none
module mfos_flash
	import mfos_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       tick,
	input  wire logic       run,
	input  wire logic       short_on,
	input  wire logic [3:0] major,
	input  wire logic [2:0] minor,
	output logic            lamp
);
	typedef enum logic [2:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP, FL_PAUSE} mfos_fl_st_t;

	mfos_fl_st_t st_r, st_nxt;
	logic [11:0] tmr_r, tmr_nxt;
	logic [3:0]  left_r, left_nxt;
	logic [2:0]  minor_r, minor_nxt;
	logic        short_r, short_nxt;
	logic        lamp_r, lamp_nxt;
	logic        expire;

	function automatic logic [11:0] on_len(input logic s);
		on_len = s ? FL_SHORT_TK : FL_ON_TK;
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	assign expire = tick && (tmr_r == 12'h001);

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		left_nxt = left_r;
		minor_nxt = minor_r;
		short_nxt = short_r;
		if (tick && tmr_r > 12'h001) begin
			tmr_nxt = tmr_r - 12'h001; // R20
		end
		if (!run) begin
			st_nxt = FL_IDLE;
		end else begin
			case (st_r)
				FL_IDLE: if (major != 4'h0) begin
					st_nxt = FL_ON;
					left_nxt = major;
					minor_nxt = minor;
					short_nxt = short_on;
					tmr_nxt = on_len(short_on);
				end
				FL_ON: if (expire) begin
					st_nxt = FL_OFF;
					tmr_nxt = FL_OFF_TK;
					left_nxt = left_r - 4'h1;
				end
				FL_OFF: if (expire) begin
					if (left_r != 4'h0) begin
						st_nxt = FL_ON;
						tmr_nxt = on_len(short_r);
					end else if (minor_r != 3'h0) begin
						st_nxt = FL_GAP;
						tmr_nxt = FL_GAP_TK;
						left_nxt = {1'b0, minor_r};
						minor_nxt = 3'h0;
					end else begin
						st_nxt = FL_PAUSE; // R15
						tmr_nxt = FL_PAUSE_TK;
					end
				end
				FL_GAP: if (expire) begin
					st_nxt = FL_ON;
					tmr_nxt = on_len(short_r);
				end
				FL_PAUSE: if (expire) begin
					st_nxt = FL_IDLE; // R15
				end
				default: st_nxt = FL_IDLE;
			endcase
		end
		lamp_nxt = (st_nxt == FL_ON);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r <= FL_IDLE;
			tmr_r <= 12'h000;
			left_r <= 4'h0;
			minor_r <= 3'h0;
			short_r <= 1'b0;
			lamp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			left_r <= left_nxt;
			minor_r <= minor_nxt;
			short_r <= short_nxt;
			lamp_r <= lamp_nxt;
		end
	end

	assign lamp = lamp_r;
endmodule // mfos_flash
`default_nettype wire

//--- mfos_load_model.sv
// Model of the loads on the output pins: lamps, beeper, status LED, gauge
// Assumes pin levels from the selector, sampled on mclk
`timescale 1ns/1ps
`default_nettype none
module mfos_load_model
	import mfos_pkg::*;
#(
	parameter logic PULL = 1'b1
)(
	input  wire logic        mclk,
	input  wire logic        clr,
	input  wire logic [1:0]  hc_out,
	input  wire logic        lc_out,
	input  wire logic        lc_oe,
	output logic [15:0]      hc0_off,
	output logic [15:0]      hc1_off,
	output logic [15:0]      lc_off,
	output logic [15:0]      lc_hi
);
	// ****************************************
	// Pin level and event counters
	// ****************************************
	logic       pin;
	logic [1:0] hc_q;
	logic       pin_q;

	// Released pin pulled to B+ through the sink LED
	assign pin = lc_oe ? lc_out : PULL;

	always_ff @(posedge mclk) begin
		hc_q  <= hc_out;
		pin_q <= pin;
		if (clr) begin
			hc0_off <= 16'h0;
			hc1_off <= 16'h0;
			lc_off  <= 16'h0;
			lc_hi   <= 16'h0;
		end else begin
			hc0_off <= hc0_off + 16'(hc_q[0] & ~hc_out[0]);
			hc1_off <= hc1_off + 16'(hc_q[1] & ~hc_out[1]);
			lc_off  <= lc_off + 16'(~pin_q & pin);
			lc_hi   <= lc_hi + 16'(lc_oe & lc_out);
		end
	end
endmodule // mfos_load_model
`default_nettype wire

//--- mfos_pkg.sv
// Package for the multi-function output selector: functions, config, timing
// Assumes a single 40 MHz clock and a 1 ms tick made by the top module
`default_nettype none
package mfos_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int MCLK_HZ        = 40_000_000;
	localparam int TICK_US        = 1000;
	localparam int FLASH_ON_MS    = 250;
	localparam int FLASH_SHORT_MS = 100;
	localparam int FLASH_OFF_MS   = 250;
	localparam int FLASH_GAP_MS   = 750;
	localparam int FLASH_PAUSE_MS = 1500;
	localparam logic [11:0] FL_ON_TK    = 12'(FLASH_ON_MS * 1000 / TICK_US);
	localparam logic [11:0] FL_SHORT_TK = 12'(FLASH_SHORT_MS * 1000 / TICK_US);
	localparam logic [11:0] FL_OFF_TK   = 12'(FLASH_OFF_MS * 1000 / TICK_US);
	localparam logic [11:0] FL_GAP_TK   = 12'(FLASH_GAP_MS * 1000 / TICK_US);
	localparam logic [11:0] FL_PAUSE_TK = 12'(FLASH_PAUSE_MS * 1000 / TICK_US);

	// ****************************************
	// Functions and modes
	// ****************************************
	typedef enum logic [2:0] {MFOS_HC_NONE, MFOS_HC_BRAKE, MFOS_HC_REVERSE, MFOS_HC_BEEPER,
		MFOS_HC_STATUS, MFOS_HC_POWER} mfos_hc_fn_t;
	typedef enum logic [2:0] {MFOS_LC_NONE, MFOS_LC_STAT_HI, MFOS_LC_STAT_LO, MFOS_LC_GAUGE5,
		MFOS_LC_GAUGE12, MFOS_LC_DIGITAL} mfos_lc_fn_t;
	typedef enum logic [1:0] {MFOS_SET_SCOOTER, MFOS_SET_TYPE2, MFOS_SET_TYPE3,
		MFOS_SET_TYPE4} mfos_code_set_t;
	typedef enum logic [1:0] {MFOS_FC_NORMAL, MFOS_FC_INHIBIT, MFOS_FC_LIMP} mfos_fclass_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		mfos_hc_fn_t [1:0] hc_fn;
		mfos_lc_fn_t       lc_fn;
		mfos_code_set_t    code_set;
		logic              key_ind;
		logic              beep_en;
		logic              flash_beep;
		logic              deep_en;
	} mfos_cfg_t;
	typedef struct packed {
		logic fwd_decel;
		logic rev_decel;
		logic rev_dir;
	} mfos_drive_t;
	typedef struct packed {
		logic         active;
		logic [3:0]   major;
		logic [2:0]   minor;
		mfos_fclass_t fclass;
	} mfos_fault_t;
	typedef struct packed {
		logic       start;
		logic       charge;
		logic       flash;
		logic [4:0] bars;
	} mfos_dg_frame_t;

	// ****************************************
	// Reset values and fixed figures
	// ****************************************
	localparam mfos_cfg_t MFOS_CFG_RST = '{hc_fn: '{MFOS_HC_POWER, MFOS_HC_BEEPER},
		lc_fn: MFOS_LC_NONE, code_set: MFOS_SET_SCOOTER, key_ind: 1'b1,
		beep_en: 1'b0, flash_beep: 1'b0, deep_en: 1'b0};
	localparam logic [3:0] DEEP_MAJOR  = 4'h2;
	localparam logic [7:0] GAUGE5_NUM  = 8'h6B;
	localparam logic [3:0] DG_SLOTS    = 4'hF;
endpackage
`default_nettype wire

//--- mfos_top.sv
// Multi-function output selector: two high-current pins and one low-current pin
// Assumes drive, fault and battery inputs come from logic on mclk
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: High-current pins each pick a function, defaults
// R2: Function none keeps the pin inactive
// R3: Brake lamp on while decelerating either direction
// R4: Reverse lamp on while reversing
// R5: Beeper silent unless beeper enable set
// R6: Status steady on, flash code on fault
// R7: Power indicator always on, never flashes
// R8: Low-current pin picks one of six functions
// R9: Active-high status sources current to LED
// R10: Active-low status sinks LED current
// R11: Analogue gauge level scaled to full scale
// R12: Digital gauge shows charging animation when inhibited
// R13: Digital gauge flashes code, bars show battery
// R14: Key indicator driven only when enabled
// R15: Flash group, pause, repeat while condition lasts
// R16: Flash code beeper sounds the flash pattern
// R17: Four code sets, active set reported
// R18: Fault class permits, inhibits or limps drive
// R19: Deep discharge two short flashes, top priority
// R20: Flash timings counted from system clock
module mfos_top
	import mfos_pkg::*;
#(
	parameter int unsigned TICK_CYC = MCLK_HZ / 1_000_000 * TICK_US
)(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        cfg_wr,
	input  wire mfos_cfg_t   cfg_in,
	input  wire mfos_drive_t drv,
	input  wire mfos_fault_t flt,
	input  wire logic        batt_low_cut,
	input  wire logic        charge_inh,
	input  wire logic        beep_event,
	input  wire logic [7:0]  batt_level,
	output logic [1:0]       hc_out,
	output logic             lc_out,
	output logic             lc_oe,
	output logic             key_led,
	output logic             drive_allow,
	output logic             limp_mode,
	output mfos_code_set_t   code_set
);
	mfos_cfg_t      cfg_r, cfg_nxt;
	logic [15:0]    tick_cnt_r, tick_cnt_nxt;
	logic           tick;
	logic           deep, show, lamp, status_on, beep;
	logic           show_r, show_nxt;
	logic [3:0]     fl_major;
	logic [2:0]     fl_minor;
	logic [1:0]     hc_r, hc_nxt;
	logic           lc_out_r, lc_out_nxt;
	logic           lc_oe_r, lc_oe_nxt;
	logic           key_r, key_nxt;
	logic           allow_r, allow_nxt;
	logic           limp_r, limp_nxt;
	logic [7:0]     pwm_r, pwm_nxt;
	logic [7:0]     duty;
	logic [15:0]    scaled;
	logic [3:0]     slot_r, slot_nxt;
	logic [7:0]     sh_r, sh_nxt;
	logic [2:0]     anim_r, anim_nxt;
	mfos_dg_frame_t frame;

	function automatic logic hc_drive(input mfos_hc_fn_t fn, input logic brake,
		input logic rev, input logic bp, input logic st);
		case (fn)
			MFOS_HC_BRAKE:   hc_drive = brake; // R3
			MFOS_HC_REVERSE: hc_drive = rev; // R4
			MFOS_HC_BEEPER:  hc_drive = bp; // R5
			MFOS_HC_STATUS:  hc_drive = st; // R6
			MFOS_HC_POWER:   hc_drive = 1'b1; // R7
			default:         hc_drive = 1'b0; // R2
		endcase
	endfunction

	// ****************************************
	// Configuration and tick divider
	// ****************************************
	always_comb begin
		cfg_nxt = cfg_wr ? cfg_in : cfg_r; // R1 R8
		show_nxt = show;
		tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001; // R20
	end

	assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_r <= MFOS_CFG_RST; // R1 R8 R14
			tick_cnt_r <= 16'h0000;
			show_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			show_r <= show_nxt;
		end
	end

	// ****************************************
	// Flash code selection
	// ****************************************
	assign deep = cfg_r.deep_en && batt_low_cut; // R19
	assign show = deep || flt.active;
	assign fl_major = deep ? DEEP_MAJOR : flt.major; // R19
	assign fl_minor = (deep || cfg_r.code_set != MFOS_SET_TYPE4) ? 3'h0 : flt.minor; // R17

	mfos_flash u_flash (
		.mclk     (mclk),
		.rstn     (rstn),
		.tick     (tick),
		.run      (show),
		.short_on (deep),
		.major    (fl_major),
		.minor    (fl_minor),
		.lamp     (lamp)
	);

	// Held on in the first cycle of show, while show_r is still low, then follows lamp
	assign status_on = (show && show_r) ? lamp : 1'b1; // R6 R9 R10
	assign beep = cfg_r.beep_en && (beep_event || (show && lamp && (deep || cfg_r.flash_beep))); // R5 R16 R19

	// ****************************************
	// Gauge pwm and digital gauge frame
	// ****************************************
	assign scaled = {8'h00, batt_level} * {8'h00, GAUGE5_NUM};
	assign duty = (cfg_r.lc_fn == MFOS_LC_GAUGE5) ? scaled[15:8] : batt_level; // R11
	assign frame = '{start: 1'b0, charge: charge_inh, flash: show && lamp,
		bars: {2'b00, charge_inh ? anim_r : batt_level[7:5]}}; // R12 R13

	always_comb begin
		pwm_nxt = pwm_r + 8'h01;
		slot_nxt = slot_r;
		sh_nxt = sh_r;
		anim_nxt = anim_r;
		if (tick) begin
			slot_nxt = (slot_r == DG_SLOTS) ? 4'h0 : slot_r + 4'h1;
			if (slot_r == 4'h0) begin
				sh_nxt = frame;
				anim_nxt = charge_inh ? anim_r + 3'h1 : 3'h0; // R12
			end else begin
				sh_nxt = {sh_r[6:0], 1'b1};
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pwm_r <= 8'h00;
			slot_r <= 4'h0;
			sh_r <= 8'hFF;
			anim_r <= 3'h0;
		end else begin
			pwm_r <= pwm_nxt;
			slot_r <= slot_nxt;
			sh_r <= sh_nxt;
			anim_r <= anim_nxt;
		end
	end

	// ****************************************
	// Output pins
	// ****************************************
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			hc_nxt[i] = hc_drive(cfg_r.hc_fn[i], drv.fwd_decel || drv.rev_decel,
				drv.rev_dir, beep, status_on); // R1
		end
		lc_out_nxt = 1'b0;
		lc_oe_nxt = 1'b0;
		case (cfg_r.lc_fn)
			MFOS_LC_STAT_HI: begin
				lc_out_nxt = status_on; // R9
				lc_oe_nxt = 1'b1;
			end
			MFOS_LC_STAT_LO: begin
				lc_out_nxt = 1'b0; // R10
				lc_oe_nxt = status_on;
			end
			MFOS_LC_GAUGE5, MFOS_LC_GAUGE12: begin
				lc_out_nxt = (pwm_r < duty); // R11
				lc_oe_nxt = 1'b1;
			end
			MFOS_LC_DIGITAL: begin
				lc_out_nxt = sh_r[7]; // R12 R13
				lc_oe_nxt = 1'b1;
			end
			default: begin
				lc_out_nxt = 1'b0; // R2 R8
				lc_oe_nxt = 1'b0;
			end
		endcase
		key_nxt = cfg_r.key_ind; // R14
		allow_nxt = !(flt.active && flt.fclass == MFOS_FC_INHIBIT); // R18
		limp_nxt = flt.active && flt.fclass == MFOS_FC_LIMP; // R18
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hc_r <= 2'h0;
			lc_out_r <= 1'b0;
			lc_oe_r <= 1'b0;
			key_r <= 1'b0;
			allow_r <= 1'b1;
			limp_r <= 1'b0;
		end else begin
			hc_r <= hc_nxt;
			lc_out_r <= lc_out_nxt;
			lc_oe_r <= lc_oe_nxt;
			key_r <= key_nxt;
			allow_r <= allow_nxt;
			limp_r <= limp_nxt;
		end
	end

	assign hc_out = hc_r;
	assign lc_out = lc_out_r;
	assign lc_oe = lc_oe_r;
	assign key_led = key_r;
	assign drive_allow = allow_r;
	assign limp_mode = limp_r;
	assign code_set = cfg_r.code_set; // R17

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	property p_none_off;
		cfg_r.hc_fn[0] == MFOS_HC_NONE |=> !hc_out[0];
	endproperty
	a_none_off: assert property (p_none_off) else $error("none pin active"); // R2

	property p_brake;
		(cfg_r.hc_fn[1] == MFOS_HC_BRAKE) && (drv.fwd_decel || drv.rev_decel) |=> hc_out[1];
	endproperty
	a_brake: assert property (p_brake) else $error("brake lamp off while decelerating"); // R3

	property p_reverse;
		(cfg_r.hc_fn[0] == MFOS_HC_REVERSE) |=> hc_out[0] == $past(drv.rev_dir);
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse lamp wrong"); // R4

	property p_beep_mute;
		(cfg_r.hc_fn[0] == MFOS_HC_BEEPER) && !cfg_r.beep_en |=> !hc_out[0];
	endproperty
	a_beep_mute: assert property (p_beep_mute) else $error("beeper sounds while disabled"); // R5

	property p_status_steady;
		(cfg_r.hc_fn[0] == MFOS_HC_STATUS) && !show |=> hc_out[0];
	endproperty
	a_status_steady: assert property (p_status_steady) else $error("status off without fault"); // R6

	property p_power_on;
		(cfg_r.hc_fn[1] == MFOS_HC_POWER) && flt.active |=> hc_out[1];
	endproperty
	a_power_on: assert property (p_power_on) else $error("power indicator flashes"); // R7

	property p_stat_lo;
		cfg_r.lc_fn == MFOS_LC_STAT_LO |=> !lc_out && (lc_oe == $past(status_on));
	endproperty
	a_stat_lo: assert property (p_stat_lo) else $error("active-low status wrong"); // R10

	property p_stat_hi;
		cfg_r.lc_fn == MFOS_LC_STAT_HI |=> lc_oe && (lc_out == $past(status_on));
	endproperty
	a_stat_hi: assert property (p_stat_hi) else $error("active-high status wrong"); // R9

	property p_lc_none;
		cfg_r.lc_fn == MFOS_LC_NONE |=> !lc_oe && !lc_out;
	endproperty
	a_lc_none: assert property (p_lc_none) else $error("unused low-current pin driven"); // R8

	property p_key;
		cfg_wr && !cfg_in.key_ind |=> ##1 !key_led;
	endproperty
	a_key: assert property (p_key) else $error("key indicator still driven"); // R14

	property p_flash_len;
		$rose(lamp) |-> lamp[*8];
	endproperty
	a_flash_len: assert property (p_flash_len) else $error("flash too short"); // R20

	property p_deep_prio;
		deep |-> fl_major == DEEP_MAJOR && fl_minor == 3'h0;
	endproperty
	a_deep_prio: assert property (p_deep_prio) else $error("deep warning not on top"); // R19

	property p_inhibit;
		flt.active && flt.fclass == MFOS_FC_INHIBIT |=> !drive_allow && !limp_mode;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("drive not inhibited"); // R18

	c_deep: cover property (deep && lamp);
	c_two_digit: cover property (flt.active && cfg_r.code_set == MFOS_SET_TYPE4 && flt.minor != 3'h0 && lamp);
	c_charging: cover property (cfg_r.lc_fn == MFOS_LC_DIGITAL && charge_inh && tick);
	c_brake: cover property (cfg_r.hc_fn[1] == MFOS_HC_BRAKE && hc_out[1]);
	c_stat_hi: cover property (cfg_r.lc_fn == MFOS_LC_STAT_HI && show && !lamp);
endmodule // mfos_top
`default_nettype wire

//--- tb_multi_function_output_select.sv
// Self-checking bench for the output selector
// Assumes mfos_top with TICK_CYC shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_multi_function_output_select
	import mfos_pkg::*;
;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic           mclk = 1'b0;
	logic           rstn;
	logic           cfg_wr;
	mfos_cfg_t      cfg_in;
	mfos_cfg_t      cv;
	mfos_drive_t    drv;
	mfos_fault_t    flt;
	logic           batt_low_cut;
	logic           charge_inh;
	logic           beep_event;
	logic [7:0]     batt_level;
	logic [1:0]     hc_out;
	logic           lc_out;
	logic           lc_oe;
	logic           key_led;
	logic           drive_allow;
	logic           limp_mode;
	mfos_code_set_t code_set;
	logic           clr;
	logic [15:0]    hc0_off;
	logic [15:0]    hc1_off;
	logic [15:0]    lc_off;
	logic [15:0]    lc_hi;
	int             err_count = 0;
	int             checks = 0;
	int             cyc = 0;

	always #12.5 mclk = ~mclk;

	mfos_top #(.TICK_CYC(10)) DUT (.mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
		.drv(drv), .flt(flt), .batt_low_cut(batt_low_cut), .charge_inh(charge_inh),
		.beep_event(beep_event), .batt_level(batt_level), .hc_out(hc_out), .lc_out(lc_out),
		.lc_oe(lc_oe), .key_led(key_led), .drive_allow(drive_allow), .limp_mode(limp_mode),
		.code_set(code_set));

	mfos_load_model LOAD (.mclk(mclk), .clr(clr), .hc_out(hc_out), .lc_out(lc_out), .lc_oe(lc_oe),
		.hc0_off(hc0_off), .hc1_off(hc1_off), .lc_off(lc_off), .lc_hi(lc_hi));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d, err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask

	task automatic cfg();
		@(posedge mclk);
		#2;
		cfg_in = cv;
		cfg_wr = 1'b1;
		step(1);
		cfg_wr = 1'b0;
		step(2);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			give_verdict();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_defaults();
		check(16'(hc_out), 16'h2, "reset pins");
		check(16'(key_led), 16'h1, "key led");
		check(16'(lc_oe), 16'h0, "lc idle");
		check(16'(code_set), 16'(MFOS_SET_SCOOTER), "code set");
	endtask

	task automatic t_lamps();
		mfos_hc_fn_t fn[6];
		logic [2:0]  dv[6];
		logic        ex[6];
		fn = '{MFOS_HC_NONE, MFOS_HC_BRAKE, MFOS_HC_BRAKE, MFOS_HC_BRAKE, MFOS_HC_REVERSE, MFOS_HC_REVERSE};
		dv = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h1, 3'h4};
		ex = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 6; i++) begin
			cv.hc_fn[0] = fn[i];
			cv.hc_fn[1] = fn[i];
			cfg();
			drv = dv[i];
			step(2);
			check(16'(hc_out[0]), 16'(ex[i]), "lamp pin");
			check(16'(hc_out[1]), 16'(ex[i]), "lamp pin b");
		end
		drv = '0;
		cv.hc_fn[0] = MFOS_HC_BEEPER;
		beep_event = 1'b1;
		cfg();
		check(16'(hc_out[0]), 16'h0, "beeper muted");
		cv.beep_en = 1'b1;
		cfg();
		check(16'(hc_out[0]), 16'h1, "beeper on");
		beep_event = 1'b0;
	endtask

	task automatic t_fclass();
		for (int i = 0; i < 3; i++) begin
			flt = '{active: 1'b1, major: 4'h0, minor: 3'h0, fclass: mfos_fclass_t'(i)};
			step(2);
			check(16'(drive_allow), 16'(i != 1), "drive allow");
			check(16'(limp_mode), 16'(i == 2), "limp");
		end
		flt = '0;
	endtask

	task automatic t_flash();
		cv = MFOS_CFG_RST;
		cv.hc_fn[0] = MFOS_HC_STATUS;
		cv.lc_fn = MFOS_LC_STAT_LO;
		cv.key_ind = 1'b0;
		cv.code_set = MFOS_SET_TYPE4;
		cfg();
		check(16'(key_led), 16'h0, "key led off");
		check(16'(hc_out[0]), 16'h1, "status steady");
		flt = '{active: 1'b1, major: 4'h2, minor: 3'h1, fclass: MFOS_FC_NORMAL};
		clr = 1'b0;
		step(24000);
		check(hc0_off, 16'h3, "status flashes");
		check(hc1_off, 16'h0, "power steady");
		check(lc_off, 16'h3, "sink led flashes");
		flt = '0;
		step(3);
		check(16'(hc_out[0]), 16'h1, "status after clear");
		clr = 1'b1;
	endtask

	task automatic t_deep();
		cv.hc_fn[1] = MFOS_HC_BEEPER;
		cv.beep_en = 1'b1;
		cv.deep_en = 1'b1;
		cfg();
		flt = '{active: 1'b1, major: 4'h5, minor: 3'h0, fclass: MFOS_FC_NORMAL};
		batt_low_cut = 1'b1;
		clr = 1'b0;
		step(20000);
		check(hc0_off, 16'h2, "deep flashes");
		check(hc1_off, 16'h2, "deep beeps");
		flt = '0;
		batt_low_cut = 1'b0;
		clr = 1'b1;
		cv.deep_en = 1'b0;
		cv.flash_beep = 1'b1;
		cv.code_set = MFOS_SET_TYPE3;
		cfg();
		check(16'(code_set), 16'(MFOS_SET_TYPE3), "set reported");
		flt = '{active: 1'b1, major: 4'h1, minor: 3'h0, fclass: MFOS_FC_NORMAL};
		clr = 1'b0;
		step(16000);
		check(hc0_off, 16'h1, "one flash");
		check(hc1_off, 16'h1, "code beeps");
		flt = '0;
		clr = 1'b1;
	endtask

	task automatic t_gauge();
		cv.lc_fn = MFOS_LC_GAUGE12;
		batt_level = 8'h40;
		cfg();
		clr = 1'b0;
		step(256);
		check(16'(lc_hi >= 16'h3F && lc_hi <= 16'h41), 16'h1, "gauge12 duty");
		clr = 1'b1;
		cv.lc_fn = MFOS_LC_GAUGE5;
		batt_level = 8'hFF;
		cfg();
		clr = 1'b0;
		step(256);
		check(16'(lc_hi >= 16'h69 && lc_hi <= 16'h6B), 16'h1, "gauge5 duty");
		clr = 1'b1;
		cv.lc_fn = MFOS_LC_NONE;
		cfg();
		check(16'({lc_oe, lc_out}), 16'h0, "lc none");
	endtask

	task automatic t_lowside();
		cv.lc_fn = MFOS_LC_STAT_HI;
		cfg();
		check(16'({lc_oe, lc_out}), 16'h3, "source led steady");
		flt = '{active: 1'b1, major: 4'h1, minor: 3'h0, fclass: MFOS_FC_NORMAL};
		step(2600);
		check(16'({lc_oe, lc_out}), 16'h2, "source led flash gap");
		flt = '0;
		batt_level = 8'hA0;
		cv.lc_fn = MFOS_LC_DIGITAL;
		cfg();
		step(200);
		clr = 1'b0;
		step(160);
		check(lc_hi, 16'h0064, "gauge frame bars");
		clr = 1'b1;
		flt = '{active: 1'b1, major: 4'h1, minor: 3'h0, fclass: MFOS_FC_NORMAL};
		step(200);
		clr = 1'b0;
		step(160);
		check(lc_hi, 16'h006E, "gauge frame flash");
		clr = 1'b1;
		flt = '0;
		charge_inh = 1'b1;
		step(200);
		clr = 1'b0;
		step(1280);
		check(lc_hi, 16'h0348, "gauge charging");
		clr = 1'b1;
		charge_inh = 1'b0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		cfg_wr = 1'b0;
		cfg_in = MFOS_CFG_RST;
		cv = MFOS_CFG_RST;
		drv = '0;
		flt = '0;
		batt_low_cut = 1'b0;
		charge_inh = 1'b0;
		beep_event = 1'b0;
		batt_level = 8'h0;
		clr = 1'b1;
		step(12);
		rstn = 1'b1;
		step(2);
		t_defaults();
		t_lamps();
		t_fclass();
		t_flash();
		t_deep();
		t_gauge();
		t_lowside();
		give_verdict();
	end
endmodule // tb_multi_function_output_select
`default_nettype wire
